// File: hw/strain_conv_map.svh
// Purpose: Offsets, field positions, reset values and timing figures of the conversion
//          sequencer and time stamp block.
// Assumes: A 200 MHz system clock.
// Notes:   Times are given in microseconds; cycle counts are derived from them.
`ifndef STRAIN_CONV_MAP_SVH
`define STRAIN_CONV_MAP_SVH

`define CLK_MHZ             200
`define CYC_PER_US          (`CLK_MHZ * 1)
`define CHAN_SPACING_US     47
`define WRAP_SPACING_US     59
`define MIN_BUS_CYCLE_US    200
`define ADDR_W              10
`define OFS_CONV_COUNTER    10'h101
`define OFS_CONV_STAMP      10'h10C
`define CHAN_IDX_LSB        0
`define CHAN_IDX_MSB        1
`define CYCLE_CTR_LSB       2
`define CYCLE_CTR_MSB       7
`define CONV_COUNTER_RST    8'h00
`define CONV_STAMP_RST      32'h0000_0000
`define NUM_CHANNELS        4

`endif

// File: hw/strain_conv_pkg.sv
// Purpose: Types shared by the conversion sequencer and time stamp block.
// Assumes: Constants come from strain_conv_map.svh.
// Notes:   None.
package strain_conv_pkg;

  typedef enum logic [0:0] {
    SEQ_WAIT,
    SEQ_BUSY
  } seq_state_e;

  typedef logic [1:0]         chan_idx_t;
  typedef logic signed [31:0] stamp_t;

endpackage : strain_conv_pkg

// File: hw/strain_conv_timestamp.sv
// Purpose: Conversion sequencing and microsecond time stamping of a four channel
//          multiplexed bridge readout, with a cyclic process data read port.
// Assumes: The converter and the bus controller logic run on clk_i.
// Notes:   Reads return the process image latched at the last bus cycle.
// Operation
// [RULE_01] Bits 2 to 7 of the counter register count finished conversion cycles.
// [RULE_02] A cycle is complete only after all four channels converted once.
// [RULE_03] Time stamp holds the completion time of the latest conversion, that channel.
// [RULE_04] Time stamp is a full signed 32-bit value.
// [RULE_05] Channels convert 1,2,3,4; 47 us apart, 59 us from 4 back to 1.
// [RULE_06] Controller derives other channel times by subtracting the fixed spacings.
// [RULE_07] Controller keeps its bus cycle at 200 us or longer.
// [RULE_08] Process data is refreshed every bus cycle of at least 200 us.
// [RULE_09] Bits 0 to 1 hold last converted channel, 0 to 3 for inputs 1 to 4.
// [RULE_10] One converter is shared by the four channels through a multiplexer.
// [RULE_11] Microsecond time wraps modulo two to the thirty-second power.
`timescale 1ns/1ps
`include "strain_conv_map.svh"

module strain_conv_timestamp
  import strain_conv_pkg::*;
(
  input  wire logic                 clk_i,
  input  wire logic                 rst_b_i,
  input  wire logic                 ce_i,
  input  wire logic                 time_load_i,
  input  wire logic [31:0]          synchronized_network_time_i,
  input  wire logic                 adc_done_i,
  output logic                      adc_start_o,
  output logic [1:0]                adc_channel_o,
  input  wire logic                 bus_cycle_i,
  input  wire logic                 rd_en_i,
  input  wire logic [`ADDR_W-1:0]   rd_addr_i,
  output logic [31:0]               rd_data_o,
  output logic                      rd_valid_o,
  output logic                      rd_error_o,
  output logic                      bus_cycle_short_o
);

  localparam logic [7:0] CycPerUsM1 = 8'(`CYC_PER_US - 1);
  localparam logic [7:0] ChanGapUs  = 8'(`CHAN_SPACING_US);
  localparam logic [7:0] WrapGapUs  = 8'(`WRAP_SPACING_US);
  localparam logic [7:0] MinBusUs   = 8'(`MIN_BUS_CYCLE_US);

  logic                        rst_meta_q;
  logic                        rst_b_q;
  logic [7:0]                  presc_q;
  logic                        us_tick;
  logic [31:0]                 time_q;
  seq_state_e                  state_q;
  logic [7:0]                  gap_q;
  logic [7:0]                  gap_target;
  chan_idx_t                   next_chan_q;
  chan_idx_t                   busy_chan_q;
  logic [`NUM_CHANNELS-1:0]    done_mask_q;
  logic [`NUM_CHANNELS-1:0]    done_mask_set;
  logic [1:0]                  last_chan_q;
  logic [5:0]                  cycle_ctr_q;
  stamp_t                      stamp_q;
  logic [7:0]                  image_counter_q;
  stamp_t                      image_stamp_q;
  logic [7:0]                  bus_gap_q;
  logic                        bus_seen_q;

  // Reset is released through two flops; only the synchronised copy is used below.
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      rst_meta_q <= 1'b0;
      rst_b_q    <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_b_q    <= rst_meta_q;
    end
  end

  // Microsecond prescaler.
  assign us_tick = ce_i && (presc_q == CycPerUsM1);

  always_ff @(posedge clk_i or negedge rst_b_q)
  begin
    if (!rst_b_q)
    begin
      presc_q <= 8'h00;
    end
    else if (ce_i)
    begin
      presc_q <= (presc_q == CycPerUsM1) ? 8'h00 : presc_q + 8'h01;
    end
  end

  // Local microsecond time, loadable from the synchronised network time.
  always_ff @(posedge clk_i or negedge rst_b_q)
  begin
    if (!rst_b_q)
    begin
      time_q <= 32'h0000_0000;
    end
    else if (ce_i)
    begin
      if (time_load_i)
      begin
        time_q <= synchronized_network_time_i;
      end
      else if (us_tick)
      begin
        time_q <= time_q + 32'h0000_0001; // [RULE_11]
      end
    end
  end

  // The gap before channel 1 is the longer wrap gap.
  assign gap_target = (next_chan_q == 2'h0) ? WrapGapUs : ChanGapUs; // [RULE_05]

  // Sequencer: a single converter is started for one channel at a time.
  always_ff @(posedge clk_i or negedge rst_b_q)
  begin
    if (!rst_b_q)
    begin
      state_q     <= SEQ_WAIT;
      gap_q       <= 8'h00;
      next_chan_q <= 2'h0;
      busy_chan_q <= 2'h0;
    end
    else if (ce_i)
    begin
      unique case (state_q)
        SEQ_WAIT:
        begin
          if (us_tick)
          begin
            gap_q <= gap_q + 8'h01;
          end
          if (gap_q >= gap_target)
          begin
            state_q     <= SEQ_BUSY; // [RULE_10]
            busy_chan_q <= next_chan_q;
            next_chan_q <= next_chan_q + 2'h1; // [RULE_05]
            gap_q       <= 8'h00;
          end
        end
        SEQ_BUSY:
        begin
          if (us_tick)
          begin
            gap_q <= gap_q + 8'h01;
          end
          if (adc_done_i)
          begin
            state_q <= SEQ_WAIT;
          end
        end
      endcase
    end
  end

  assign adc_start_o   = ce_i && (state_q == SEQ_WAIT) && (gap_q >= gap_target);

  // The channel stays put through a conversion and moves on only once it has ended.
  always_ff @(posedge clk_i or negedge rst_b_q)
  begin
    if (!rst_b_q)
    begin
      adc_channel_o <= 2'h0;
    end
    else if (ce_i && adc_done_i && (state_q == SEQ_BUSY))
    begin
      adc_channel_o <= next_chan_q; // [RULE_05]
    end
  end

  // Record of channels converted in the running cycle.
  assign done_mask_set = done_mask_q | (`NUM_CHANNELS'(1) << busy_chan_q);

  always_ff @(posedge clk_i or negedge rst_b_q)
  begin
    if (!rst_b_q)
    begin
      done_mask_q <= '0;
    end
    else if (ce_i && adc_done_i && (state_q == SEQ_BUSY))
    begin
      if (busy_chan_q == 2'h3)
      begin
        done_mask_q <= '0;
      end
      else
      begin
        done_mask_q <= done_mask_set;
      end
    end
  end

  // Last channel index, cycle counter and completion time stamp.
  always_ff @(posedge clk_i or negedge rst_b_q)
  begin
    if (!rst_b_q)
    begin
      last_chan_q <= 2'(`CONV_COUNTER_RST >> `CHAN_IDX_LSB);
      cycle_ctr_q <= 6'(`CONV_COUNTER_RST >> `CYCLE_CTR_LSB);
      stamp_q     <= `CONV_STAMP_RST;
    end
    else if (ce_i && adc_done_i && (state_q == SEQ_BUSY))
    begin
      last_chan_q <= busy_chan_q; // [RULE_09]
      stamp_q     <= stamp_t'(time_q); // [RULE_03] [RULE_04]
      if ((busy_chan_q == 2'h3) && (&done_mask_set))
      begin
        cycle_ctr_q <= cycle_ctr_q + 6'h01; // [RULE_01] [RULE_02]
      end
    end
  end

  // Process image taken once per bus cycle so counter and stamp always belong together.
  always_ff @(posedge clk_i or negedge rst_b_q)
  begin
    if (!rst_b_q)
    begin
      image_counter_q <= `CONV_COUNTER_RST;
      image_stamp_q   <= `CONV_STAMP_RST;
    end
    else if (ce_i && bus_cycle_i)
    begin
      image_counter_q[`CYCLE_CTR_MSB:`CYCLE_CTR_LSB] <= cycle_ctr_q; // [RULE_08]
      image_counter_q[`CHAN_IDX_MSB:`CHAN_IDX_LSB]   <= last_chan_q;
      image_stamp_q                                   <= stamp_q;
    end
  end

  // Watch the bus cycle length; a short cycle is flagged until the next cycle.
  always_ff @(posedge clk_i or negedge rst_b_q)
  begin
    if (!rst_b_q)
    begin
      bus_gap_q         <= 8'h00;
      bus_seen_q        <= 1'b0;
      bus_cycle_short_o <= 1'b0;
    end
    else if (ce_i)
    begin
      if (bus_cycle_i)
      begin
        bus_cycle_short_o <= bus_seen_q && (bus_gap_q < MinBusUs); // [RULE_07]
        bus_seen_q        <= 1'b1;
        bus_gap_q         <= 8'h00;
      end
      else if (us_tick && (bus_gap_q != 8'hFF))
      begin
        bus_gap_q <= bus_gap_q + 8'h01;
      end
    end
  end

  // Read port at the printed register numbers; other addresses answer zero with an error.
  always_ff @(posedge clk_i or negedge rst_b_q)
  begin
    if (!rst_b_q)
    begin
      rd_data_o  <= 32'h0000_0000;
      rd_valid_o <= 1'b0;
      rd_error_o <= 1'b0;
    end
    else if (ce_i)
    begin
      rd_valid_o <= rd_en_i;
      rd_error_o <= 1'b0;
      rd_data_o  <= 32'h0000_0000;
      if (rd_en_i)
      begin
        if (rd_addr_i == `OFS_CONV_COUNTER)
        begin
          rd_data_o <= {24'h00_0000, image_counter_q};
        end
        else if (rd_addr_i == `OFS_CONV_STAMP)
        begin
          rd_data_o <= image_stamp_q;
        end
        else
        begin
          rd_error_o <= 1'b1;
        end
      end
    end
  end

endmodule : strain_conv_timestamp

// File: tb/adc_model.sv
// Purpose: Converter stand-in that answers each start after a fixed delay.
// Assumes: Starts never come closer than the delay.
// Notes:   One converter serves all four channels.
`timescale 1ns/1ps
module adc_model #(parameter int CONV = 300) (
  input  wire logic clk_i,
  input  wire logic start_i,
  output logic      done_o
);
  int cnt_q = 0;
  initial done_o = 1'b0;
  always @(posedge clk_i)
  begin
    done_o <= cnt_q == 1;
    cnt_q  <= start_i ? CONV : (cnt_q > 0 ? cnt_q - 1 : 0);
  end
endmodule : adc_model

// File: tb/strain_conv_timestamp_asserts.sv
// Purpose: Port checks of the conversion sequencer and time stamp block.
// Assumes: Clock enable high; 200 clocks make one microsecond.
// Notes:   Spacing windows allow for the tick phase.
`timescale 1ns/1ps
module strain_conv_timestamp_asserts (
  input wire logic        clk_i,
  input wire logic        rst_b_i,
  input wire logic        ce_i,
  input wire logic        rd_en_i,
  input wire logic [9:0]  rd_addr_i,
  input wire logic [31:0] rd_data_o,
  input wire logic        rd_valid_o,
  input wire logic        rd_error_o,
  input wire logic        adc_start_o,
  input wire logic [1:0]  adc_channel_o,
  input wire logic        bus_cycle_i,
  input wire logic        bus_cycle_short_o
);
  int         gap_q;
  int         bus_q;
  logic       seen_q;
  logic [1:0] ch_q;
  always_ff @(posedge clk_i or negedge rst_b_i)
    if (!rst_b_i)
    begin
      gap_q  <= 0;
      bus_q  <= 40200;
      seen_q <= 1'b0;
      ch_q   <= 2'h0;
    end
    else
    begin
      gap_q  <= adc_start_o ? 1 : gap_q + 1;
      bus_q  <= bus_cycle_i ? 1 : (bus_q < 40200 ? bus_q + 1 : bus_q);
      seen_q <= seen_q | adc_start_o;
      ch_q   <= adc_start_o ? adc_channel_o : ch_q;
    end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  property p_rd_valid; ce_i && rd_en_i |=> rd_valid_o; endproperty
  a_rd_valid: assert property (p_rd_valid) else $error("read lost");
  property p_unmapped; ce_i && rd_en_i && rd_addr_i != 10'h101 && rd_addr_i != 10'h10C
    |=> rd_error_o && rd_data_o == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("bad unmapped");
  property p_ctr; ce_i && rd_en_i && rd_addr_i == 10'h101
    |=> !rd_error_o && rd_data_o[31:8] == 24'h0; endproperty
  a_ctr: assert property (p_ctr) else $error("counter width");
  property p_first; adc_start_o && !seen_q |-> adc_channel_o == 2'h0; endproperty
  a_first: assert property (p_first) else $error("first channel");
  property p_order; adc_start_o && seen_q |-> adc_channel_o == ch_q + 2'h1; endproperty
  a_order: assert property (p_order) else $error("channel order");
  property p_pulse; adc_start_o |=> !adc_start_o; endproperty
  a_pulse: assert property (p_pulse) else $error("start too long");
  property p_gap; adc_start_o && seen_q |-> (adc_channel_o == 2'h0 ?
    gap_q inside {[11600:11802]} : gap_q inside {[9200:9402]}); endproperty
  a_gap: assert property (p_gap) else $error("start spacing");
  property p_short; bus_cycle_i && ce_i && bus_q < 39800 |=> bus_cycle_short_o; endproperty
  a_short: assert property (p_short) else $error("short missed");
  property p_long; bus_cycle_i && ce_i && bus_q >= 40200 |=> !bus_cycle_short_o; endproperty
  a_long: assert property (p_long) else $error("false short");
endmodule : strain_conv_timestamp_asserts
bind strain_conv_timestamp strain_conv_timestamp_asserts strain_conv_timestamp_asserts_i (.*);

// File: tb/tb_top.sv
// Purpose: Self-checking bench of the conversion sequencer and time stamp block.
// Assumes: The converter model answers each start after a fixed delay.
// Notes:   Stamps are checked as spacings, so the load phase does not matter.
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
  $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module tb_top;
  import strain_conv_pkg::*;
  typedef struct {logic [32:0] v; bit rel;} exp_s;
  logic        clk_i = 0;
  logic        rst_b_i = 0;
  logic        ce_i = 1;
  logic        time_load_i = 0;
  logic [31:0] synchronized_network_time_i = 32'h0000_0000;
  logic        adc_done_i;
  logic        adc_start_o;
  logic [1:0]  adc_channel_o;
  logic        bus_cycle_i = 0;
  logic        rd_en_i = 0;
  logic [9:0]  rd_addr_i = 10'h000;
  logic [31:0] rd_data_o;
  logic        rd_valid_o;
  logic        rd_error_o;
  logic        bus_cycle_short_o;
  logic [31:0] last;
  int          tests_run = 0;
  int          n_mismatch = 0;
  exp_s        exp_q[$];
  exp_s        e;
  strain_conv_timestamp strain_conv_timestamp_i (.*);
  adc_model adc_model_i (.clk_i, .start_i(adc_start_o), .done_o(adc_done_i));
  initial forever #2.5 clk_i = ~clk_i;
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : test_done
  task automatic step;
    @(posedge clk_i);
    #1;
  endtask : step
  task automatic rd(input logic [9:0] a, input logic [32:0] v, input bit rel);
    exp_q.push_back('{v, rel});
    rd_addr_i = a;
    rd_en_i = 1'b1;
    step();
  endtask : rd
  task automatic bus_pulse;
    bus_cycle_i = 1'b1;
    step();
    bus_cycle_i = 1'b0;
    step();
  endtask : bus_pulse
  always @(posedge clk_i)
    if (rd_valid_o === 1'b1)
    begin
      `CHK("note", 1'b1, exp_q.size() > 0)
      if (exp_q.size() > 0)
        e = exp_q.pop_front();
      if (!e.rel)
        `CHK("read", e.v, {rd_error_o, rd_data_o})
      else if (!e.v[32])
        `CHK("spacing", e.v[31:0], rd_data_o - last)
      if (e.rel)
        last = rd_data_o;
    end
  initial
  begin
    void'($urandom(32'hA267E4DC));
    repeat (16) @(posedge clk_i);
    #1 rst_b_i = 1'b1;
    repeat (3) step();
    rd(10'h101, 33'h0, 0);
    rd(10'h10C, 33'h0, 0);
    rd_en_i = 1'b0;
    synchronized_network_time_i = 32'h7FFF_FF40 + ($urandom & 32'h3F);
    time_load_i = 1'b1;
    step();
    time_load_i = 1'b0;
    for (int k = 0; k < 5; k++)
    begin
      while (adc_done_i !== 1'b1)
        step();
      step();
      bus_pulse();
      `CHK("short", k > 0, bus_cycle_short_o)
      rd(10'h101, {25'h0, 6'((k + 1) / 4), 2'(k)}, 0);
      rd(10'h10C, k ? ((k % 4) ? 33'h2F : 33'h3B) : 33'h1_0000_0000, 1);
      rd_en_i = 1'b0;
    end
    rd(10'($urandom_range(255)), {1'b1, 32'h0}, 0);
    rd_en_i = 1'b0;
    repeat (41000) step();
    bus_pulse();
    `CHK("long", 1'b0, bus_cycle_short_o)
    `CHK("wrap", 1'b1, $signed(last) < 0)
    `CHK("pending", 0, exp_q.size())
    test_done();
  end
  initial
  begin
    repeat (100000) @(posedge clk_i);
    n_mismatch++;
    test_done();
  end
endmodule : tb_top
